// file: verilog/write_guard_defines.svh
// Constants for the peripheral write guard: offsets, bit map, sizes
`ifndef WRITE_GUARD_DEFINES_SVH
`define WRITE_GUARD_DEFINES_SVH

`define WG_ADDR_W        8
`define WG_DATA_W        32
`define WG_NUM_PERIPH    7
`define WG_OFS_CLEAR     8'h00
`define WG_OFS_SET       8'h04
`define WG_OFS_STATUS    8'h08
`define WG_OFS_MASK      8'h0C
`define WG_PROT_RESET    7'h00
`define WG_PROT_VALID    7'h7E
`define WG_BIT_PM        1
`define WG_BIT_SYSCTL    2
`define WG_BIT_GENERIC_CLOCK_UNIT      3
`define WG_BIT_WDOG      4
`define WG_BIT_RTC       5
`define WG_BIT_EXTINT    6
`define WG_EVT_W         3
`define WG_EVT_BLOCKED   0
`define WG_EVT_DBL_SET   1
`define WG_EVT_DBL_CLR   2
`define WG_EVT_RESET     3'h0
`define WG_BYTE_EN_W     4

`endif

// file: verilog/write_guard_pkg.sv
// Types shared by the peripheral write guard files
package write_guard_pkg;

  // One register access from the bus master
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  byte_en;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // One peripheral write seen on the guarded path
  typedef struct packed {
    logic       valid;
    logic [2:0] periph;
  } periph_wr_t;

  // Bus answer state
  typedef enum logic [2:0] {
    ANS_IDLE  = 3'b001,
    ANS_OK    = 3'b010,
    ANS_ERROR = 3'b100
  } answer_state_t;

endpackage

// file: verilog/protect_bits.sv
// Protect bit store: set/clear views with double-operation detection
`include "write_guard_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module protect_bits (
  input  wire logic                        core_clk, // System clock
  input  wire logic                        nrst,     // Sync reset, low
  input  wire logic                        set_we,   // Set view write
  input  wire logic                        clr_we,   // Clear view write
  input  wire logic [`WG_NUM_PERIPH-1:0]   wmask,    // Ones of the write
  output logic      [`WG_NUM_PERIPH-1:0]   prot,     // Protect bits
  output logic                             dbl_err   // Double op now
);

  logic [`WG_NUM_PERIPH-1:0] prot_q; // Stored protect bits
  logic [`WG_NUM_PERIPH-1:0] prot_d; // Next protect bits
  logic [`WG_NUM_PERIPH-1:0] eff;    // Ones aimed at mapped bits

  assign prot = prot_q;

  // Unmapped positions never act nor fault (see [RULE12])
  assign eff = wmask & `WG_PROT_VALID;

  // Double protect or double unprotect (see [RULE5]) (see [RULE6])
  assign dbl_err = (set_we && |(eff & prot_q)) ||
                   (clr_we && |(eff & ~prot_q));

  // Next protect bits
  always_comb begin
    prot_d = prot_q;
    if (dbl_err) begin
      prot_d = prot_q;             // Faulting write changes nothing (see [RULE13])
    end else if (set_we) begin
      prot_d = prot_q | eff;       // Ones protect, zeros keep (see [RULE2]) (see [RULE7])
    end else if (clr_we) begin
      prot_d = prot_q & ~eff;      // Ones unprotect, zeros keep (see [RULE1]) (see [RULE7])
    end
  end

  // Register, all clear at reset (see [RULE11])
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prot_q <= `WG_PROT_RESET;
    end else begin
      prot_q <= prot_d;
    end
  end

endmodule

`default_nettype wire

// file: verilog/peripheral_write_guard.sv
// Peripheral write guard top: register port, write filter, interrupt
//
// Functional notes
// [RULE1] Clear-view one unprotects peripheral in both views
// [RULE2] Set-view one protects peripheral in both views
// [RULE3] Both views read the same protect bits
// [RULE4] Writes to protected peripheral dropped, error returned
// [RULE5] Setting already-protected bit returns an error
// [RULE6] Clearing already-unprotected bit returns an error
// [RULE7] Written zeros leave protect bits unchanged
// [RULE8] Byte, halfword and word accesses all supported
// [RULE9] Bit 3 guards generic clock unit
// [RULE10] Map: 6 ext-int,5 rtc,4 wdog,3 clk,2 sys,1 pm
// [RULE11] Clear at 0x00, set at 0x04, reset zero
// [RULE12] Unmapped bits read zero, ignore writes, no error
// [RULE13] Double-op error keeps bits, same transfer answers
//
// Our own choices: the register addresses and the strobed register port.
`include "write_guard_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module peripheral_write_guard (
  input  wire logic                      core_clk,    // 25 MHz clock
  input  wire logic                      nrst,        // Sync reset, low
  input  wire logic [`WG_ADDR_W-1:0]     reg_addr,    // Register byte addr
  input  wire logic [`WG_DATA_W-1:0]     reg_wdata,   // Write data
  input  wire logic [`WG_BYTE_EN_W-1:0]  reg_byte_en, // Byte lanes
  input  wire logic                      reg_wr,      // Write strobe
  input  wire logic                      reg_rd,      // Read strobe
  output logic      [`WG_DATA_W-1:0]     reg_rdata,   // Read data, next cycle
  output logic                           reg_err,     // Error, next cycle
  input  wire logic                      pwr_valid,   // Peripheral write
  input  wire logic [2:0]                pwr_periph,  // Its peripheral index
  output logic                           pwr_pass,    // Write let through
  output logic                           pwr_err,     // Write refused
  output logic      [`WG_NUM_PERIPH-1:0] prot_state,  // Protect bits
  output logic                           irq          // Interrupt level
);

  // ==========================================================
  // Decoding
  // ==========================================================

  // Register hit at an offset, any byte inside the word (see [RULE8])
  function automatic logic hit(input logic [`WG_ADDR_W-1:0] a,
                               input logic [`WG_ADDR_W-1:0] ofs);
    hit = (a[`WG_ADDR_W-1:2] == ofs[`WG_ADDR_W-1:2]);
  endfunction

  // Byte-lane mask over a 32-bit word (see [RULE8])
  function automatic logic [`WG_DATA_W-1:0] lanes(
      input logic [`WG_BYTE_EN_W-1:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  write_guard_pkg::reg_req_t   req;   // Bundled request
  write_guard_pkg::periph_wr_t pwr;   // Bundled peripheral write

  assign req = '{addr: reg_addr, wdata: reg_wdata, byte_en: reg_byte_en,
                 wr: reg_wr, rd: reg_rd};
  assign pwr = '{valid: pwr_valid, periph: pwr_periph};

  logic [`WG_DATA_W-1:0]     wmasked;   // Data gated by lanes
  logic                      set_we;    // Set view write
  logic                      clr_we;    // Clear view write
  logic [`WG_NUM_PERIPH-1:0] prot;      // Current protect bits
  logic                      dbl_err;   // Double operation

  assign wmasked = req.wdata & lanes(req.byte_en);
  assign set_we  = req.wr && hit(req.addr, `WG_OFS_SET);   // see [RULE11]
  assign clr_we  = req.wr && hit(req.addr, `WG_OFS_CLEAR); // see [RULE11]

  // ==========================================================
  // Protect bits
  // ==========================================================

  // Store with map of bits 1..6 (see [RULE9]) (see [RULE10])
  protect_bits u_bits (
    .core_clk (core_clk),
    .nrst     (nrst),
    .set_we   (set_we),
    .clr_we   (clr_we),
    .wmask    (wmasked[`WG_NUM_PERIPH-1:0]),
    .prot     (prot),
    .dbl_err  (dbl_err)
  );

  // ==========================================================
  // Peripheral write filter
  // ==========================================================

  logic blocked;   // Write aimed at protected peripheral
  logic pass_q;    // Registered pass
  logic pass_d;    // Next pass
  logic perr_q;    // Registered refuse
  logic perr_d;    // Next refuse

  // Protected target drops the write (see [RULE4])
  assign blocked = pwr.valid && prot[pwr.periph];

  // Filter answers
  always_comb begin
    pass_d = pwr.valid && !blocked;
    perr_d = blocked;  // see [RULE4]
  end

  // Register filter answers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pass_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      pass_q <= pass_d;
      perr_q <= perr_d;
    end
  end

  // ==========================================================
  // Interrupt status and mask
  // ==========================================================

  logic [`WG_EVT_W-1:0] evt;     // Events this cycle
  logic [`WG_EVT_W-1:0] stat_q;  // Sticky status
  logic [`WG_EVT_W-1:0] stat_d;  // Next status
  logic [`WG_EVT_W-1:0] mask_q;  // Interrupt mask
  logic [`WG_EVT_W-1:0] mask_d;  // Next mask
  logic                 irq_q;   // Registered interrupt
  logic                 irq_d;   // Next interrupt
  logic                 st_we;   // Status write
  logic                 mk_we;   // Mask write

  assign st_we = req.wr && hit(req.addr, `WG_OFS_STATUS);
  assign mk_we = req.wr && hit(req.addr, `WG_OFS_MASK);

  // Event vector
  always_comb begin
    evt = `WG_EVT_RESET;
    evt[`WG_EVT_BLOCKED] = blocked;
    evt[`WG_EVT_DBL_SET] = set_we && dbl_err;
    evt[`WG_EVT_DBL_CLR] = clr_we && dbl_err;
  end

  // Write-one-to-clear; a new event wins over its clear
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (st_we) begin
      stat_d = stat_q & ~wmasked[`WG_EVT_W-1:0];
    end
    stat_d = stat_d | evt;
    if (mk_we) begin
      mask_d = wmasked[`WG_EVT_W-1:0];
    end
    irq_d = |(stat_d & mask_d);
  end

  // Register status, mask and interrupt
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stat_q <= `WG_EVT_RESET;
      mask_q <= `WG_EVT_RESET;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
    end
  end

  // ==========================================================
  // Bus answer
  // ==========================================================

  logic [`WG_DATA_W-1:0]         rdata_q;  // Read data
  logic [`WG_DATA_W-1:0]         rdata_d;  // Next read data
  write_guard_pkg::answer_state_t ans_q;   // Answer state
  write_guard_pkg::answer_state_t ans_d;   // Next answer state

  // Read mux and answer state
  always_comb begin
    rdata_d = '0;
    ans_d   = write_guard_pkg::ANS_IDLE;
    if (req.rd) begin
      ans_d = write_guard_pkg::ANS_OK;
      if (hit(req.addr, `WG_OFS_CLEAR) || hit(req.addr, `WG_OFS_SET)) begin
        // Same value on both views, unmapped read zero (see [RULE3])
        rdata_d[`WG_NUM_PERIPH-1:0] = prot & `WG_PROT_VALID; // see [RULE12]
      end else if (hit(req.addr, `WG_OFS_STATUS)) begin
        rdata_d[`WG_EVT_W-1:0] = stat_q;
      end else if (hit(req.addr, `WG_OFS_MASK)) begin
        rdata_d[`WG_EVT_W-1:0] = mask_q;
      end else begin
        ans_d = write_guard_pkg::ANS_ERROR;  // Unmapped read
      end
    end else if (req.wr) begin
      // Double operation answered on this transfer (see [RULE13])
      if (dbl_err) begin
        ans_d = write_guard_pkg::ANS_ERROR;  // see [RULE5] see [RULE6]
      end else if (set_we || clr_we || st_we || mk_we) begin
        ans_d = write_guard_pkg::ANS_OK;
      end else begin
        ans_d = write_guard_pkg::ANS_ERROR;  // Unmapped write
      end
    end
    // Lane the read data to the addressed bytes (see [RULE8])
    rdata_d = rdata_d & lanes(req.byte_en);
  end

  // Register bus answer
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_q <= '0;
      ans_q   <= write_guard_pkg::ANS_IDLE;
    end else begin
      rdata_q <= rdata_d;
      ans_q   <= ans_d;
    end
  end

  // Protect state mirror
  logic [`WG_NUM_PERIPH-1:0] pstate_q; // Registered copy

  // Register protect state for the output
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pstate_q <= `WG_PROT_RESET;
    end else begin
      pstate_q <= prot;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================

  assign reg_rdata  = rdata_q;
  assign reg_err    = (ans_q == write_guard_pkg::ANS_ERROR);
  assign pwr_pass   = pass_q;
  assign pwr_err    = perr_q;
  assign prot_state = pstate_q;
  assign irq        = irq_q;

endmodule

`default_nettype wire

// file: test/write_guard_sva.sv
// Assertions on the write guard top ports
`include "write_guard_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module write_guard_sva (
  input wire logic                   core_clk,    // Clock
  input wire logic                   nrst,        // Reset, low
  input wire logic [`WG_ADDR_W-1:0]  reg_addr,    // Address
  input wire logic [31:0]            reg_wdata,   // Write data
  input wire logic [3:0]             reg_byte_en, // Lanes
  input wire logic                   reg_wr,      // Write strobe
  input wire logic                   reg_rd,      // Read strobe
  input wire logic [31:0]            reg_rdata,   // Read data
  input wire logic                   reg_err,     // Bus error
  input wire logic                   pwr_valid,   // Peripheral write
  input wire logic [2:0]             pwr_periph,  // Its target
  input wire logic                   pwr_pass,    // Let through
  input wire logic                   pwr_err,     // Refused
  input wire logic [6:0]             prot_state,  // Protect bits
  input wire logic                   irq          // Interrupt
);
  // ==========
  // Clocking and lane-0 view writes
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  logic set_w; // Set view write touching lane 0
  logic clr_w; // Clear view write touching lane 0
  assign set_w = reg_wr && reg_addr == `WG_OFS_SET && reg_byte_en[0];
  assign clr_w = reg_wr && reg_addr == `WG_OFS_CLEAR && reg_byte_en[0];
  property p_set_view;
    set_w ##1 !reg_err |=> prot_state[6:1] ==
      ($past(prot_state[6:1]) | $past(reg_wdata[6:1], 2));
  endproperty
  a_set_view: assert property (p_set_view)
    else $error("set view write not applied");
  property p_clr_view;
    clr_w ##1 !reg_err |=> prot_state[6:1] ==
      ($past(prot_state[6:1]) & ~$past(reg_wdata[6:1], 2));
  endproperty
  a_clr_view: assert property (p_clr_view)
    else $error("clear view write not applied");
  property p_dbl_set;
    set_w ##1 1'h1 |-> reg_err == |(prot_state[6:1] & $past(reg_wdata[6:1]));
  endproperty
  a_dbl_set: assert property (p_dbl_set)
    else $error("double protect error wrong");
  property p_dbl_clr;
    clr_w ##1 1'h1 |-> reg_err == |(~prot_state[6:1] & $past(reg_wdata[6:1]));
  endproperty
  a_dbl_clr: assert property (p_dbl_clr)
    else $error("double unprotect error wrong");
  property p_dbl_keep;
    (set_w || clr_w) ##1 reg_err |=> $stable(prot_state);
  endproperty
  a_dbl_keep: assert property (p_dbl_keep)
    else $error("refused write changed protect bits");
  property p_views_read;
    reg_rd && (reg_addr == `WG_OFS_CLEAR || reg_addr == `WG_OFS_SET) |=>
      !reg_err && reg_rdata == ($past(reg_byte_en[0]) ? {25'h0, prot_state} : 32'h0);
  endproperty
  a_views_read: assert property (p_views_read)
    else $error("view read wrong");
  property p_bit0_zero;
    prot_state[0] == 1'h0;
  endproperty
  a_bit0_zero: assert property (p_bit0_zero)
    else $error("unmapped bit set");
  property p_block;
    pwr_valid |=> pwr_err == prot_state[$past(pwr_periph)] && pwr_pass == !pwr_err;
  endproperty
  a_block: assert property (p_block)
    else $error("peripheral write filter wrong");
  property p_pwr_idle;
    !pwr_valid |=> !pwr_pass && !pwr_err;
  endproperty
  a_pwr_idle: assert property (p_pwr_idle)
    else $error("filter answer without write");
endmodule
`default_nettype wire

// file: test/cpu_master.sv
// Bus master model of the processor core on the register port
`timescale 1ns/1ns
`default_nettype none
module cpu_master (
  input  wire logic        core_clk,    // Clock
  output logic [7:0]       reg_addr,    // Address
  output logic [31:0]      reg_wdata,   // Write data
  output logic [3:0]       reg_byte_en, // Lanes
  output logic             reg_wr,      // Write strobe
  output logic             reg_rd,      // Read strobe
  input  wire logic [31:0] reg_rdata,   // Read data
  input  wire logic        reg_err,     // Bus error
  output logic [31:0]      got_data,    // Captured read data
  output logic             got_err      // Captured error
);
  // Idle bus at time zero
  initial begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_byte_en = 4'h0;
  end
  // One strobe cycle; released lines show junk, answer taken next cycle
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    reg_byte_en <= be;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    reg_byte_en <= ~be;
    @(negedge core_clk);
    got_data = reg_rdata;
    got_err = reg_err;
  endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the peripheral write guard
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        core_clk, nrst, reg_wr, reg_rd, reg_err;    // Clock, bus
  logic        pwr_valid, pwr_pass, pwr_err, irq, got_err; // Filter, irq
  logic [7:0]  reg_addr;                                   // Address
  logic [31:0] reg_wdata, reg_rdata, got_data, d;          // Data words
  logic [3:0]  reg_byte_en, be;                            // Lanes
  logic [2:0]  pwr_periph;                                 // Target
  logic [6:0]  prot_state, exp_p;                          // Protect bits
  logic [15:0] lfsr;                                       // Random state
  logic        s, e;                                       // View, error
  int          mismatches, checked, cycles;                // Counters
  peripheral_write_guard peripheral_write_guard_inst (.core_clk, .nrst,
    .reg_addr, .reg_wdata, .reg_byte_en, .reg_wr, .reg_rd, .reg_rdata,
    .reg_err, .pwr_valid, .pwr_periph, .pwr_pass, .pwr_err, .prot_state,
    .irq);
  cpu_master cpu_master_inst (.core_clk, .reg_addr, .reg_wdata,
    .reg_byte_en, .reg_wr, .reg_rd, .reg_rdata, .reg_err, .got_data,
    .got_err);
  // Free-running 25 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  // Random steps
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Whether a view write is a double operation
  function automatic logic dbl(input logic v, input logic [6:0] p,
                               input logic [6:0] w);
    return |((v ? p : ~p) & w & 7'h7E);
  endfunction
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // One peripheral write through the filter
  task automatic pw(input logic [2:0] p);
    @(posedge core_clk);
    pwr_valid <= 1'h1;
    pwr_periph <= p;
    @(posedge core_clk);
    pwr_valid <= 1'h0;
    pwr_periph <= ~p;
    @(negedge core_clk);
    chk(32'({pwr_err, pwr_pass}), 32'({exp_p[p], ~exp_p[p]}));
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    {nrst, pwr_valid, pwr_periph, exp_p, mismatches, checked, cycles} = '0;
    lfsr = 16'h0023;
    repeat (5) @(posedge core_clk);
    nrst <= 1'h1;
    for (int v = 0; v < 2; v++) begin
      cpu_master_inst.xfer(1'h0, 8'(4 * v), 32'h0, 4'hF);
      chk(got_data, 32'h0);
    end
    // Random protect and unprotect traffic, byte to word lanes
    repeat (80) begin
      lfsr = nxt(nxt(nxt(lfsr)));
      s = lfsr[5];
      d = {lfsr[15:13], 21'h0, 1'h0, lfsr[6:1] & lfsr[12:7], lfsr[13]};
      be = {lfsr[9], lfsr[10], lfsr[11], lfsr[3] | lfsr[4]};
      cpu_master_inst.xfer(1'h1, s ? 8'h04 : 8'h00, d, be);
      e = be[0] && dbl(s, exp_p, d[6:0]);
      chk(32'(got_err), 32'(e));
      if (be[0] && !e) exp_p = s ? exp_p | (d[6:0] & 7'h7E) : exp_p & ~d[6:0];
      cpu_master_inst.xfer(1'h0, lfsr[7] ? 8'h04 : 8'h00, 32'h0, be);
      chk(got_data, be[0] ? {25'h0, exp_p} : 32'h0);
      pw(3'(lfsr[15:13] % 7));
    end
    // Interrupt: clear flags, unmask blocked-write flag only
    cpu_master_inst.xfer(1'h1, 8'h08, 32'h7, 4'hF);
    cpu_master_inst.xfer(1'h1, 8'h0C, 32'h1, 4'hF);
    if (!exp_p[3]) begin
      cpu_master_inst.xfer(1'h1, 8'h04, 32'h8, 4'hF);
      exp_p[3] = 1'h1;
    end
    pw(3'h3);
    @(negedge core_clk);
    chk(32'(irq), 32'h1);
    cpu_master_inst.xfer(1'h1, 8'h04, 32'h8, 4'hF);
    chk(32'(got_err), 32'h1);
    cpu_master_inst.xfer(1'h0, 8'h08, 32'h0, 4'hF);
    chk(got_data, 32'h3);
    cpu_master_inst.xfer(1'h1, 8'h08, 32'h1, 4'hF);
    @(negedge core_clk);
    chk(32'(irq), 32'h0);
    cpu_master_inst.xfer(1'h0, 8'h10, 32'h0, 4'hF);
    chk(32'(got_err), 32'h1);
    give_verdict();
  end
endmodule
bind peripheral_write_guard write_guard_sva write_guard_sva_inst (.core_clk,
  .nrst, .reg_addr, .reg_wdata, .reg_byte_en, .reg_wr, .reg_rd, .reg_rdata,
  .reg_err, .pwr_valid, .pwr_periph, .pwr_pass, .pwr_err, .prot_state, .irq);
`default_nettype wire
